// file: rtl/rfc_conv.sv
// two-channel cr-oscillation resistance to frequency converter
// assumes pins arrive asynchronously; register port is owned by one master on mclk
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rfc_conv
  import rfc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [3:0]        clock_source_tick,
  input  wire logic              debug_mode,
  input  wire logic [NUM_CH-1:0] oscillation_input_pin,
  output logic      [NUM_CH-1:0] reference_drive_pin_out,
  output logic      [NUM_CH-1:0] reference_drive_pin_oe_b,
  output logic      [NUM_CH-1:0] sensor_a_drive_pin_out,
  output logic      [NUM_CH-1:0] sensor_a_drive_pin_oe_b,
  output logic      [NUM_CH-1:0] sensor_b_drive_pin_out,
  output logic      [NUM_CH-1:0] sensor_b_drive_pin_oe_b,
  output logic      [NUM_CH-1:0] oscillation_monitor_pin,
  output logic      [NUM_CH-1:0] irq
);
  logic [DATA_W-1:0] ch_rdata [NUM_CH];
  logic [3:0]        idx;

  assign idx = reg_addr[3:0];

  // ==========================================================
  // channels
  // ==========================================================
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic             wr_ch;
      logic [1:0]       src_sel;
      logic [1:0]       div_sel;
      logic             run_in_debug;
      logic             channel_enable;
      logic [1:0]       oscillation_mode_select;
      logic             external_clock_enable;
      logic             continuous_osc;
      logic [NUM_IF-1:0] interrupt_flags;
      logic [NUM_IF-1:0] interrupt_enables;
      logic [CNT_W-1:0] measurement_counter;
      logic [CNT_W-1:0] timebase_counter;
      rfc_state_t       st;
      rfc_state_t       next_st;
      logic [CNT_W-1:0] next_mc;
      logic [CNT_W-1:0] next_tc;
      logic [NUM_IF-1:0] ev;
      logic             freeze;
      logic             op_tick;
      logic             osc_s1;
      logic             osc_s2;
      logic             osc_s3;
      logic             osc_edge;
      logic             trg_wr;
      logic             running;
      logic             osc_on;
      logic             fb;
      logic             ac;

      assign wr_ch  = reg_wr && (reg_addr[CH_BIT] == 1'(ch));
      assign trg_wr = wr_ch && (idx == REG_TRG);
      assign freeze = debug_mode && !run_in_debug;
      assign ac     = (oscillation_mode_select == MODE_AC);

      rfc_opclk u_opclk (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .src_tick (clock_source_tick),
        .src_sel  (src_sel),
        .div_sel  (div_sel),
        .hold     (freeze),
        .op_tick  (op_tick)
      );

      // the first stage feeds only the second; edges are taken later
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          osc_s1 <= 1'b0;
          osc_s2 <= 1'b0;
          osc_s3 <= 1'b0;
        end
        else
        begin
          osc_s1 <= oscillation_input_pin[ch];
          osc_s2 <= osc_s1;
          osc_s3 <= osc_s2;
        end
      end

      // same edge count for internal oscillation and external pulses
      assign osc_edge = osc_s2 && !osc_s3 && !freeze;

      // ======================================================
      // configuration registers
      // ======================================================
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          src_sel      <= 2'h0;
          div_sel      <= 2'h0;
          run_in_debug <= 1'b0;
        end
        else if (wr_ch && idx == REG_CLK)
        begin
          src_sel      <= reg_wdata[CLK_SRC_LSB +: 2];
          div_sel      <= reg_wdata[CLK_DIV_LSB +: 2];
          run_in_debug <= reg_wdata[CLK_RUN_IN_DEBUG];
        end
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          channel_enable          <= 1'b0;
          oscillation_mode_select <= MODE_DC;
          external_clock_enable   <= 1'b0;
          continuous_osc          <= 1'b0;
        end
        else if (wr_ch && idx == REG_CTL)
        begin
          channel_enable          <= reg_wdata[CTL_EN];
          oscillation_mode_select <= reg_wdata[CTL_MODE_LSB +: 2];
          external_clock_enable   <= reg_wdata[CTL_EXT];
          continuous_osc          <= reg_wdata[CTL_CONT];
        end
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          interrupt_enables <= '0;
        else if (wr_ch && idx == REG_INTE)
          interrupt_enables <= reg_wdata[NUM_IF-1:0];
      end

      // a flag raised in the clearing cycle survives the clear
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          interrupt_flags <= '0;
        else if (wr_ch && idx == REG_INTF)
          interrupt_flags <= (interrupt_flags & ~reg_wdata[NUM_IF-1:0]) | ev;
        else
          interrupt_flags <= interrupt_flags | ev;
      end

      assign irq[ch] = |(interrupt_flags & interrupt_enables);

      // ======================================================
      // measurement sequence
      // ======================================================
      always_comb
      begin
        next_st = st;
        next_mc = measurement_counter;
        next_tc = timebase_counter;
        ev      = '0;
        unique case (st)
          RFC_IDLE:
            // starts need the channel enabled; sensor b has no pin in ac mode
            if (trg_wr && channel_enable && !freeze)
            begin
              if (reg_wdata[TRG_REF])
                next_st = RFC_REF;
              else if (reg_wdata[TRG_SENA])
                next_st = RFC_SENA;
              else if (reg_wdata[TRG_SENB] && !ac)
                next_st = RFC_SENB;
            end
          RFC_REF:
            if (trg_wr && !reg_wdata[TRG_REF])
              next_st = RFC_IDLE;
            else
            begin
              if (osc_edge)
                next_mc = measurement_counter + CNT_ONE;
              if (op_tick)
                next_tc = timebase_counter + CNT_ONE;
              ev[IF_REF]  = osc_edge && (measurement_counter == CNT_MAX);
              ev[IF_TOVF] = op_tick && (timebase_counter == CNT_MAX);
              if (ev[IF_REF] || ev[IF_TOVF])
                next_st = RFC_IDLE;
            end
          RFC_SENA, RFC_SENB:
            if (trg_wr && !reg_wdata[(st == RFC_SENA) ? TRG_SENA : TRG_SENB])
              next_st = RFC_IDLE;
            else
            begin
              if (osc_edge)
                next_mc = measurement_counter + CNT_ONE;
              if (op_tick && timebase_counter != CNT_ZERO)
                next_tc = timebase_counter - CNT_ONE;
              ev[IF_MOVF] = osc_edge && (measurement_counter == CNT_MAX);
              if (!ev[IF_MOVF] && (timebase_counter == CNT_ZERO ||
                  (op_tick && timebase_counter == CNT_ONE)))
              begin
                ev[IF_SENA] = (st == RFC_SENA);
                ev[IF_SENB] = (st == RFC_SENB);
              end
              if (|ev)
                next_st = RFC_IDLE;
            end
        endcase
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          st <= RFC_IDLE;
        else if (!channel_enable)
          st <= RFC_IDLE;
        else
          st <= next_st;
      end

      // counters load from software only while idle
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          measurement_counter <= CNT_ZERO;
        else if (st == RFC_IDLE && (next_st == RFC_SENA || next_st == RFC_SENB))
          measurement_counter <= CNT_ZERO;
        else if (st == RFC_IDLE && wr_ch && idx == REG_MCL)
          measurement_counter[15:0] <= reg_wdata;
        else if (st == RFC_IDLE && wr_ch && idx == REG_MCH)
          measurement_counter[23:16] <= reg_wdata[7:0];
        else
          measurement_counter <= next_mc;
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          timebase_counter <= CNT_ZERO;
        else if (st == RFC_IDLE && wr_ch && idx == REG_TCL)
          timebase_counter[15:0] <= reg_wdata;
        else if (st == RFC_IDLE && wr_ch && idx == REG_TCH)
          timebase_counter[23:16] <= reg_wdata[7:0];
        else
          timebase_counter <= next_tc;
      end

      // ======================================================
      // oscillation pins
      // ======================================================
      assign running = (st != RFC_IDLE);
      assign osc_on  = channel_enable && (running || continuous_osc);
      assign fb      = ~osc_s2;

      // pins hold their last level while frozen
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          reference_drive_pin_out[ch]  <= 1'b0;
          reference_drive_pin_oe_b[ch] <= 1'b1;
          sensor_a_drive_pin_out[ch]   <= 1'b0;
          sensor_a_drive_pin_oe_b[ch]  <= 1'b1;
          sensor_b_drive_pin_out[ch]   <= 1'b0;
          sensor_b_drive_pin_oe_b[ch]  <= 1'b1;
          oscillation_monitor_pin[ch]  <= 1'b0;
        end
        else if (!freeze)
        begin
          oscillation_monitor_pin[ch]  <= osc_on && osc_s2;
          reference_drive_pin_out[ch]  <= 1'b0;
          reference_drive_pin_oe_b[ch] <= 1'b1;
          sensor_a_drive_pin_out[ch]   <= 1'b0;
          sensor_a_drive_pin_oe_b[ch]  <= 1'b1;
          sensor_b_drive_pin_out[ch]   <= 1'b0;
          sensor_b_drive_pin_oe_b[ch]  <= 1'b1;
          if (osc_on && !external_clock_enable)
          begin
            if (st == RFC_SENA)
            begin
              sensor_a_drive_pin_out[ch]   <= fb;
              sensor_a_drive_pin_oe_b[ch]  <= 1'b0;
              reference_drive_pin_out[ch]  <= ~fb;
              reference_drive_pin_oe_b[ch] <= !ac;
            end
            else if (st == RFC_SENB)
            begin
              sensor_b_drive_pin_out[ch]  <= fb;
              sensor_b_drive_pin_oe_b[ch] <= 1'b0;
            end
            else
            begin
              reference_drive_pin_out[ch]  <= fb;
              reference_drive_pin_oe_b[ch] <= 1'b0;
              sensor_a_drive_pin_out[ch]   <= ~fb;
              sensor_a_drive_pin_oe_b[ch]  <= !ac;
            end
          end
        end
      end

      // ======================================================
      // read view
      // ======================================================
      // counters cross no domain here, so one read is coherent
      always_comb
      begin
        ch_rdata[ch] = RD_ZERO;
        unique case (idx)
          REG_CLK:  ch_rdata[ch] = 16'({run_in_debug, 2'h0, div_sel, 2'h0, src_sel});
          REG_CTL:  ch_rdata[ch] = 16'({continuous_osc, external_clock_enable, 2'h0,
                                        oscillation_mode_select, 3'h0, channel_enable});
          REG_TRG:  ch_rdata[ch] = 16'({st == RFC_SENB, st == RFC_SENA, st == RFC_REF});
          REG_INTF: ch_rdata[ch] = 16'(interrupt_flags);
          REG_INTE: ch_rdata[ch] = 16'(interrupt_enables);
          REG_MCL:  ch_rdata[ch] = measurement_counter[15:0];
          REG_MCH:  ch_rdata[ch] = 16'(measurement_counter[23:16]);
          REG_TCL:  ch_rdata[ch] = timebase_counter[15:0];
          REG_TCH:  ch_rdata[ch] = 16'(timebase_counter[23:16]);
          default:  ch_rdata[ch] = RD_ZERO;
        endcase
      end
    end
  endgenerate

  // ==========================================================
  // register read port
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= RD_ZERO;
    else if (reg_rd)
      reg_rdata <= ch_rdata[reg_addr[CH_BIT]];
    else
      reg_rdata <= RD_ZERO;
  end
endmodule
`default_nettype wire

// file: common/rfc_pkg.sv
// constants, field layouts and state codes for the two-channel r/f converter
// assumes a single 25 MHz clock; register port is 16 bits wide, 5-bit word address
// How it works
// - 24-bit measurement counter counts oscillation edges
// - 24-bit time base counter counts operating clock
// - five interrupt causes per channel
// - continuous oscillation, clock shown on monitor pin
// - operating clock from source and divide fields
// - debug mode suspends clock unless run bit
// - suspended channel holds pins and registers
// - run bit set keeps channel running
// - flags clear on writing one
// - one enable bit per interrupt cause
// - two-bit field picks dc or ac
// - dc mode drives sensors a and b
// - ac mode drives one sensor alternately
// - external clock bit counts input pin pulses
// - each channel keeps its own mode
// - two independent channels, 0 and 1
// - reference run: overflow stops, flags done/error
// - sensor run: time base zero ends run
// - writing zero to start bit aborts, holds counters
// - request only when flag and enable set
package rfc_pkg;
  localparam int          NUM_CH = 2;
  localparam int          ADDR_W = 5;
  localparam int          DATA_W = 16;
  localparam int          CNT_W  = 24;
  localparam int          NUM_IF = 5;

  // word index inside a channel; address bit 4 picks the channel
  localparam logic [3:0]  REG_CLK  = 4'h0;
  localparam logic [3:0]  REG_CTL  = 4'h1;
  localparam logic [3:0]  REG_TRG  = 4'h2;
  localparam logic [3:0]  REG_INTF = 4'h3;
  localparam logic [3:0]  REG_INTE = 4'h4;
  localparam logic [3:0]  REG_MCL  = 4'h5;
  localparam logic [3:0]  REG_MCH  = 4'h6;
  localparam logic [3:0]  REG_TCL  = 4'h7;
  localparam logic [3:0]  REG_TCH  = 4'h8;
  localparam int          CH_BIT   = 4;

  // clock config fields
  localparam int          CLK_SRC_LSB = 0;
  localparam int          CLK_DIV_LSB = 4;
  localparam int          CLK_RUN_IN_DEBUG   = 8;
  // control fields
  localparam int          CTL_EN      = 0;
  localparam int          CTL_MODE_LSB = 4;
  localparam int          CTL_EXT     = 8;
  localparam int          CTL_CONT    = 9;
  // start bits
  localparam int          TRG_REF  = 0;
  localparam int          TRG_SENA = 1;
  localparam int          TRG_SENB = 2;
  // flag / enable bits
  localparam int          IF_REF  = 0;
  localparam int          IF_SENA = 1;
  localparam int          IF_SENB = 2;
  localparam int          IF_MOVF = 3;
  localparam int          IF_TOVF = 4;

  localparam logic [1:0]  MODE_DC = 2'h0;
  localparam logic [1:0]  MODE_AC = 2'h1;
  localparam logic [CNT_W-1:0] CNT_MAX  = 24'hffffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    RFC_IDLE = 4'b0001,
    RFC_REF  = 4'b0010,
    RFC_SENA = 4'b0100,
    RFC_SENB = 4'b1000
  } rfc_state_t;
endpackage

// file: rtl/rfc_opclk.sv
// operating clock enable for one channel: source pick, divider, debug hold
// assumes source ticks are one-cycle enables from the clock generator on mclk
`timescale 1ns/10ps
`default_nettype none
module rfc_opclk
  import rfc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [3:0] src_tick,
  input  wire logic [1:0] src_sel,
  input  wire logic [1:0] div_sel,
  input  wire logic       hold,
  output logic            op_tick
);
  logic [2:0] div_cnt;
  logic [2:0] div_mask;
  logic       src_pulse;

  // divide by 1, 2, 4 or 8
  assign div_mask  = 3'(({1'b0, 3'h1} << div_sel) - 4'h1);
  assign src_pulse = src_tick[src_sel] & ~hold;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      div_cnt <= 3'h0;
    else if (src_pulse)
      div_cnt <= div_cnt + 3'h1;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      op_tick <= 1'b0;
    else
      op_tick <= src_pulse && ((div_cnt & div_mask) == div_mask);
  end
endmodule
`default_nettype wire

// file: verification/rfc_conv_checker.sv
// checker for the port behaviour of rfc_conv, channel 0
// assumes bind into rfc_conv; shadows the channel 0 clock, control and enable words
`timescale 1ns/10ps
`default_nettype none
module rfc_conv_checker
  import rfc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              debug_mode,
  input wire logic [NUM_CH-1:0] reference_drive_pin_out,
  input wire logic [NUM_CH-1:0] reference_drive_pin_oe_b,
  input wire logic [NUM_CH-1:0] sensor_a_drive_pin_out,
  input wire logic [NUM_CH-1:0] sensor_a_drive_pin_oe_b,
  input wire logic [NUM_CH-1:0] sensor_b_drive_pin_oe_b,
  input wire logic [NUM_CH-1:0] irq
);
  logic [DATA_W-1:0] clk0, ctl0, inte0;
  logic [4:0]        h1, h2, h3;
  // pins lag the config, so judge after four samples
  wire  [4:0]        cond = {inte0[4:0] == 5'h00, debug_mode && !clk0[CLK_RUN_IN_DEBUG],
                             ctl0[CTL_MODE_LSB +: 2] == MODE_AC, ctl0[CTL_EXT], !ctl0[CTL_EN] && !ctl0[CTL_CONT]};
  wire  [4:0]        held = cond & h1 & h2 & h3;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ==========
  // shadow registers
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      clk0  <= RD_ZERO;
      ctl0  <= RD_ZERO;
      inte0 <= RD_ZERO;
    end
    else if (reg_wr && !reg_addr[CH_BIT])
    begin
      if (reg_addr[3:0] == REG_CLK) clk0 <= reg_wdata;
      if (reg_addr[3:0] == REG_CTL) ctl0 <= reg_wdata;
      if (reg_addr[3:0] == REG_INTE) inte0 <= reg_wdata;
    end

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      h1 <= 5'h00;
      h2 <= 5'h00;
      h3 <= 5'h00;
    end
    else
    begin
      h1 <= cond;
      h2 <= h1;
      h3 <= h2;
    end

  // ==========
  // properties
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == RD_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_reset_idle;
    $rose(rst_b) |-> &reference_drive_pin_oe_b && &sensor_a_drive_pin_oe_b && irq == 2'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins or irq active after reset");
  property p_off_idle;
    held[0] |-> reference_drive_pin_oe_b[0] && sensor_a_drive_pin_oe_b[0] && sensor_b_drive_pin_oe_b[0];
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("disabled channel drives a pin");
  property p_ext_idle;
    held[1] |-> reference_drive_pin_oe_b[0] && sensor_a_drive_pin_oe_b[0] && sensor_b_drive_pin_oe_b[0];
  endproperty
  a_ext_idle: assert property (p_ext_idle)
    else $error("pin driven in external clock mode");
  property p_ac_no_b;
    held[2] |-> sensor_b_drive_pin_oe_b[0];
  endproperty
  a_ac_no_b: assert property (p_ac_no_b)
    else $error("sensor b driven in ac mode");
  property p_ac_opp;
    !reference_drive_pin_oe_b[0] && !sensor_a_drive_pin_oe_b[0]
      |-> ctl0[CTL_MODE_LSB +: 2] == MODE_AC && reference_drive_pin_out[0] != sensor_a_drive_pin_out[0];
  endproperty
  a_ac_opp: assert property (p_ac_opp)
    else $error("paired pins not in opposite polarity");
  property p_one_sensor;
    sensor_a_drive_pin_oe_b[0] || sensor_b_drive_pin_oe_b[0];
  endproperty
  a_one_sensor: assert property (p_one_sensor)
    else $error("both sensor pins driven");
  property p_freeze;
    held[3] |-> $stable(reference_drive_pin_out[0]) && $stable(reference_drive_pin_oe_b[0])
      && $stable(sensor_a_drive_pin_oe_b[0]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("pins moved while frozen");
  property p_irq_mask;
    held[4] |-> !irq[0];
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with all causes masked");
endmodule

bind rfc_conv rfc_conv_checker u_rfc_conv_checker (
  .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .debug_mode,
  .reference_drive_pin_out, .reference_drive_pin_oe_b, .sensor_a_drive_pin_out,
  .sensor_a_drive_pin_oe_b, .sensor_b_drive_pin_oe_b, .irq
);
`default_nettype wire

// file: verification/rfc_rc_net.sv
// external network: rc node per channel, or an external clock in its place
// assumes the node follows the driving pin after a fixed charge delay
`timescale 1ns/10ps
`default_nettype none
module rfc_rc_net
#(
  parameter int HALF_NS = 200
)
(
  input  wire logic [1:0] ref_out,
  input  wire logic [1:0] ref_oe_b,
  input  wire logic [1:0] sa_out,
  input  wire logic [1:0] sa_oe_b,
  input  wire logic [1:0] sb_out,
  input  wire logic [1:0] sb_oe_b,
  input  wire logic [1:0] ext_sel,
  input  wire logic [1:0] ext_clk,
  output logic      [1:0] node
);
  logic [1:0] lvl;
  logic [1:0] rc = 2'h0;

  // ==========
  // node model
  // undriven node sinks to ground through the input pull-down
  always_comb
    for (int i = 0; i < 2; i++)
      lvl[i] = !ref_oe_b[i] ? ref_out[i] : !sa_oe_b[i] ? sa_out[i] : !sb_oe_b[i] ? sb_out[i] : 1'h0;
  always @(lvl)
    rc <= #HALF_NS lvl;
  assign node = (ext_sel & ext_clk) | (~ext_sel & rc);
endmodule
`default_nettype wire

// file: verification/tb_rfc_conv.sv
// self-checking bench for rfc_conv with rc networks on both channels
// assumes 25 MHz mclk; source 0 ticks every cycle
`timescale 1ns/10ps
`default_nettype none
module tb_rfc_conv
  import rfc_pkg::*;
;
  logic              mclk = 1'h0;
  logic              rst_b = 1'h0;
  logic [ADDR_W-1:0] reg_addr = 5'h00;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr = 1'h0;
  logic              reg_rd = 1'h0;
  logic              debug_mode = 1'h0;
  logic [3:0]        tick = 4'h0;
  logic [2:0]        cyc = 3'h0;
  logic [1:0]        ext_sel = 2'h0;
  logic [1:0]        ext_clk = 2'h0;
  logic [1:0]        pin_in, ref_o, ref_e, sa_o, sa_e, sb_o, sb_e, mon, irq;
  logic              mon_q = 1'h0;
  int                mon_n = 0;
  int                seed = 94870;
  int                errors = 0;
  int                samples_checked = 0;

  rfc_conv u_rfc_conv (
    .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .debug_mode,
    .clock_source_tick(tick), .oscillation_input_pin(pin_in), .oscillation_monitor_pin(mon),
    .reference_drive_pin_out(ref_o), .reference_drive_pin_oe_b(ref_e), .sensor_a_drive_pin_out(sa_o),
    .sensor_a_drive_pin_oe_b(sa_e), .sensor_b_drive_pin_out(sb_o), .sensor_b_drive_pin_oe_b(sb_e), .irq
  );
  rfc_rc_net u_rfc_rc_net (
    .ref_out(ref_o), .ref_oe_b(ref_e), .sa_out(sa_o), .sa_oe_b(sa_e), .sb_out(sb_o), .sb_oe_b(sb_e),
    .ext_sel, .ext_clk, .node(pin_in)
  );

  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc   <= cyc + 3'h1;
    tick  <= {cyc == 3'h0, cyc[1:0] == 2'h0, cyc[0], 1'h1};
    mon_q <= mon[0];
    if (mon[0] && !mon_q)
      mon_n <= mon_n + 1;
  end

  // ==========
  // helpers
  task automatic cy(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // preset that overflows after n counts
  function automatic logic [23:0] preset(input int n);
    return 24'h000000 - n[23:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic w0(input logic [3:0] i, input logic [15:0] d);
    wr({1'h0, i}, d);
  endtask
  task automatic r0(input logic [3:0] i, output logic [15:0] d);
    rd({1'h0, i}, d);
  endtask
  task automatic wr24(input logic [3:0] i, input logic [23:0] v);
    w0(i, v[15:0]);
    w0(i + 4'h1, {8'h00, v[23:16]});
  endtask
  task automatic rd24(input logic [3:0] i, output logic [23:0] v);
    logic [15:0] lo, hi;
    r0(i, lo);
    r0(i + 4'h1, hi);
    v = {hi[7:0], lo};
  endtask
  task automatic wait_irq(input int c);
    int k;
    k = 0;
    while (irq[c] !== 1'h1 && k < 5000)
    begin
      @(posedge mclk);
      k++;
    end
    chk(irq[c], 1'h1);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========
  // tests
  initial
  begin
    logic [15:0] d;
    logic [23:0] v, t;
    int          n, m0;
    cy(8);
    rst_b <= 1'h1;
    chk({ref_e, sa_e, sb_e, irq}, 8'hfc);
    n = $unsigned($random(seed)) % 7;
    r0(4'(9 + n), d);
    chk(d, 16'h0000);
    w0(REG_TRG, 16'h0001);
    r0(REG_TRG, d);
    chk(d, 16'h0000);
    chk(ref_e[0], 1'h1);
    $display("test reset done");
    w0(REG_CLK, 16'h0000);
    w0(REG_INTF, 16'h001f);
    w0(REG_INTE, 16'h001f);
    w0(REG_CTL, 16'h0000);
    w0(REG_CTL, 16'h0001);
    n = 4 + ($unsigned($random(seed)) % 9);
    wr24(REG_MCL, preset(n));
    wr24(REG_TCL, 24'h000000);
    m0 = mon_n;
    w0(REG_TRG, 16'h0001);
    wait_irq(0);
    r0(REG_TRG, d);
    chk(d, 16'h0000);
    r0(REG_INTF, d);
    chk(d, 16'h0001);
    rd24(REG_MCL, v);
    chk(v, 24'h000000);
    chk(mon_n - m0, n);
    rd24(REG_TCL, t);
    chk(t != 24'h000000, 1'h1);
    w0(REG_INTF, 16'h0001);
    #1 chk(irq[0], 1'h0);
    m0 = mon_n;
    w0(REG_TRG, 16'h0002);
    wait_irq(0);
    r0(REG_INTF, d);
    chk(d, 16'h0002);
    rd24(REG_TCL, v);
    chk(v, 24'h000000);
    rd24(REG_MCL, v);
    chk(v, mon_n - m0);
    // time base is at zero, so sensor b ends at once
    w0(REG_TRG, 16'h0004);
    r0(REG_INTF, d);
    chk(d, 16'h0006);
    w0(REG_INTF, 16'h001f);
    $display("test reference and sensor done");
    wr24(REG_TCL, 24'h000000);
    wr24(REG_MCL, 24'h000000);
    w0(REG_TRG, 16'h0001);
    cy(40);
    debug_mode <= 1'h1;
    cy(4);
    rd24(REG_TCL, t);
    cy(30);
    rd24(REG_TCL, v);
    chk(v, t);
    chk(ref_e[0], 1'h0);
    w0(REG_CLK, 16'h0100);
    cy(30);
    rd24(REG_TCL, v);
    chk(v > t, 1'h1);
    debug_mode <= 1'h0;
    w0(REG_CLK, 16'h0000);
    w0(REG_TRG, 16'h0000);
    rd24(REG_MCL, t);
    cy(60);
    rd24(REG_MCL, v);
    chk(v, t);
    r0(REG_TRG, d);
    chk(d, 16'h0000);
    chk(ref_e[0], 1'h1);
    $display("test debug and abort done");
    w0(REG_INTE, 16'h0000);
    w0(REG_CLK, 16'h0030);
    wr24(REG_TCL, preset(6));
    w0(REG_TRG, 16'h0001);
    cy(22);
    r0(REG_INTF, d);
    chk(d, 16'h0000);
    cy(100);
    r0(REG_INTF, d);
    chk(d, 16'h0010);
    chk(irq[0], 1'h0);
    rd24(REG_TCL, v);
    chk(v, 24'h000000);
    w0(REG_INTF, 16'h001f);
    w0(REG_INTE, 16'h001f);
    w0(REG_CLK, 16'h0000);
    w0(REG_CTL, 16'h0201);
    cy(40);
    chk(ref_e[0], 1'h0);
    $display("test time base overflow done");
    w0(REG_CTL, 16'h0010);
    w0(REG_CTL, 16'h0011);
    w0(REG_TRG, 16'h0004);
    r0(REG_TRG, d);
    chk(d, 16'h0000);
    wr24(REG_TCL, 24'h0000c8);
    w0(REG_TRG, 16'h0002);
    cy(40);
    chk({ref_e[0], sa_e[0]}, 2'h0);
    wait_irq(0);
    r0(REG_INTF, d);
    chk(d, 16'h0002);
    w0(REG_INTF, 16'h001f);
    $display("test ac mode done");
    ext_sel <= 2'h1;
    w0(REG_CTL, 16'h0100);
    w0(REG_CTL, 16'h0101);
    wr({1'h1, REG_CTL}, 16'h0001);
    wr({1'h1, REG_TRG}, 16'h0001);
    wr24(REG_MCL, preset(n));
    wr24(REG_TCL, 24'h000000);
    w0(REG_TRG, 16'h0001);
    repeat (n)
    begin
      cy(3);
      ext_clk <= 2'h1;
      cy(3);
      ext_clk <= 2'h0;
    end
    cy(8);
    r0(REG_INTF, d);
    chk(d, 16'h0001);
    chk({ref_e[0], ref_e[1]}, 2'h2);
    wr({1'h1, REG_TRG}, 16'h0000);
    $display("test external clock done");
    give_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
